// *** core/compare_and_carry_complement.v ***
// Execution datapath for the compare and the invert-carry operations.
// Assumes opcode bytes, register values and memory data come from logic on CLK.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "cmp_ccf_defines.vh"

module compare_and_carry_complement (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        CE,
  input  wire        OP_VALID,
  input  wire [7:0]  OP_BYTE,
  output wire        OP_READY,
  input  wire [7:0]  ACC,
  output reg  [2:0]  REG_SEL,
  input  wire [7:0]  REG_DATA,
  input  wire [15:0] FIRST_INDEX,
  input  wire [15:0] SECOND_INDEX,
  input  wire [15:0] POINTER_PAIR,
  input  wire [15:0] STACK_POINTER,
  input  wire [15:0] PROG_COUNTER,
  output wire        MEM_REQ,
  output reg  [15:0] MEM_ADDR,
  input  wire        MEM_VALID,
  input  wire [7:0]  MEM_DATA,
  output reg  [7:0]  FLAGS,
  output reg         DONE,
  output reg         ILLEGAL,
  input  wire [3:0]  BUS_ADDR,
  input  wire [7:0]  BUS_WDATA,
  input  wire        BUS_WR,
  input  wire        BUS_RD,
  output reg  [7:0]  BUS_RDATA
);

  // Decoder states.
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PFX1 = 4'h1;
  localparam [3:0] S_PFX2 = 4'h2;
  localparam [3:0] S_IMM  = 4'h3;
  localparam [3:0] S_D8   = 4'h4;
  localparam [3:0] S_DLO  = 4'h5;
  localparam [3:0] S_DHI  = 4'h6;
  localparam [3:0] S_MEM  = 4'h7;
  localparam [3:0] S_REG  = 4'h8;

  reg [3:0]  state;
  reg [3:0]  form;
  reg [15:0] base;
  reg [7:0]  disp_lo;
  reg [7:0]  ctrl;
  reg        sx_second;

  wire       enabled;
  wire       take;
  wire [4:0] hi5;
  wire [2:0] sel;
  wire       wants_byte;

  // Compare flags from A minus source; N forced, C and H are borrows.
  function [7:0] cmp_flags;
    input [7:0] a;
    input [7:0] s;
    input [7:0] old;
    reg   [8:0] full;
    reg   [4:0] low;
    reg   [7:0] f;
    begin
      full = {1'b0, a} - {1'b0, s};
      low  = {1'b0, a[3:0]} - {1'b0, s[3:0]};
      f    = old;
      f[`FLG_S]  = full[7];
      f[`FLG_Z]  = (full[7:0] == 8'h00);
      f[`FLG_H]  = low[4];
      f[`FLG_PV] = (a[7] != s[7]) && (full[7] == s[7]);
      f[`FLG_N]  = 1'b1;
      f[`FLG_C]  = full[8];
      cmp_flags  = f;
    end
  endfunction

  // Sum of a base and a displacement, kept to 16 bits on purpose.
  function [15:0] addr_sum;
    input [15:0] b;
    input [15:0] d;
    reg   [16:0] t;
    begin
      t = {1'b0, b} + {1'b0, d};
      addr_sum = t[15:0];
    end
  endfunction

  // Pair selection for the base-index form. Selector 000 never reaches here, since it
  // decodes as the stack-relative form, so the default arm only ever sees 011.
  function [15:0] pair_sum;
    input [2:0]  f;
    input [15:0] first_idx;
    input [15:0] second_idx;
    input [15:0] pair;
    begin
      case (f)
        `SEL_PAIR_A: pair_sum = addr_sum(pair, first_idx);
        `SEL_PAIR_B: pair_sum = addr_sum(pair, second_idx);
        default:     pair_sum = addr_sum(first_idx, second_idx);
      endcase
    end
  endfunction

  assign enabled    = ctrl[`CTRL_EN];
  assign hi5        = OP_BYTE[7:3];
  assign sel        = OP_BYTE[2:0];
  assign MEM_REQ    = (state == S_MEM);
  assign wants_byte = (state == S_IDLE) || (state == S_PFX1) || (state == S_PFX2) ||
                      (state == S_IMM) || (state == S_D8) || (state == S_DLO) ||
                      (state == S_DHI);
  // Decoding stalls while an operand is being fetched, so the ready is combinational.
  assign OP_READY   = CE && enabled && wants_byte;
  assign take       = OP_READY && OP_VALID;

  // Opcode decode, operand fetch and flag update.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state     <= S_IDLE;
      form      <= `FORM_REG;
      base      <= 16'h0000;
      disp_lo   <= 8'h00;
      sx_second <= 1'b0;
      REG_SEL   <= 3'h0;
      MEM_ADDR  <= 16'h0000;
      FLAGS     <= `RST_FLAGS;
      DONE      <= 1'b0;
      ILLEGAL   <= 1'b0;
      ctrl      <= `RST_CTRL;
    end else if (CE) begin
      DONE    <= 1'b0;
      ILLEGAL <= 1'b0;
      // Software writes land first so a finishing operation overrides a FLAGS write.
      if (BUS_WR && BUS_ADDR == `REG_FLAGS)
        FLAGS <= BUS_WDATA;
      if (BUS_WR && BUS_ADDR == `REG_CTRL)
        ctrl <= BUS_WDATA;
      case (state)
        S_IDLE: begin
          if (take) begin
            if (OP_BYTE == `OPC_INVERT_CARRY) begin
              // The whole byte is written so a same-cycle software write cannot leak into
              // the kept bits; S, Z, PV and the two spare bits hold their old value.
              FLAGS         <= {FLAGS[7:5], FLAGS[`FLG_C], FLAGS[3:2], 1'b0,
                                ~FLAGS[`FLG_C]};
              form          <= `FORM_INV_CARRY;
              DONE          <= 1'b1;
            end else if (hi5 == `OPC_CMP_HI5 && sel == `SEL_INDIRECT) begin
              form     <= `FORM_IR;
              MEM_ADDR <= POINTER_PAIR;
              state    <= S_MEM;
            end else if (hi5 == `OPC_CMP_HI5) begin
              form    <= `FORM_REG;
              REG_SEL <= sel;
              state   <= S_REG;
            end else if (OP_BYTE == `OPC_IMMEDIATE) begin
              form  <= `FORM_IMM;
              state <= S_IMM;
            end else if (OP_BYTE == `OPC_PFX_FIRST) begin
              state <= S_PFX1;
            end else if (OP_BYTE == `OPC_PFX_SECOND) begin
              state <= S_PFX2;
            end else begin
              ILLEGAL <= 1'b1;
            end
          end
        end
        S_PFX1: begin
          if (take) begin
            state <= S_IDLE;
            if (hi5 != `OPC_CMP_HI5) begin
              ILLEGAL <= 1'b1;
            end else begin
              case (sel)
                `SEL_RELATIVE: begin
                  form  <= `FORM_SR;
                  base  <= STACK_POINTER;
                  state <= S_DLO;
                end
                `SEL_PAIR_A, `SEL_PAIR_B, `SEL_PAIR_C: begin
                  form     <= `FORM_BASE_INDEX;
                  MEM_ADDR <= pair_sum(sel, FIRST_INDEX, SECOND_INDEX, POINTER_PAIR);
                  state    <= S_MEM;
                end
                `SEL_HIGH_BYTE: begin
                  form  <= `FORM_RX;
                  FLAGS <= cmp_flags(ACC, FIRST_INDEX[15:8], FLAGS);
                  DONE  <= 1'b1;
                end
                `SEL_LOW_BYTE: begin
                  form  <= `FORM_RX;
                  FLAGS <= cmp_flags(ACC, FIRST_INDEX[7:0], FLAGS);
                  DONE  <= 1'b1;
                end
                `SEL_INDIRECT: begin
                  form      <= `FORM_SX;
                  sx_second <= 1'b0;
                  state     <= S_D8;
                end
                `SEL_DIRECT: begin
                  form  <= `FORM_DA;
                  base  <= 16'h0000;
                  state <= S_DLO;
                end
                default: begin
                  ILLEGAL <= 1'b1;
                end
              endcase
            end
          end
        end
        S_PFX2: begin
          if (take) begin
            state <= S_IDLE;
            if (hi5 != `OPC_CMP_HI5) begin
              ILLEGAL <= 1'b1;
            end else begin
              case (sel)
                `SEL_RELATIVE: begin
                  form  <= `FORM_RA;
                  base  <= PROG_COUNTER;
                  state <= S_DLO;
                end
                `SEL_PAIR_A: begin
                  form  <= `FORM_X;
                  base  <= FIRST_INDEX;
                  state <= S_DLO;
                end
                `SEL_PAIR_B: begin
                  form  <= `FORM_X;
                  base  <= SECOND_INDEX;
                  state <= S_DLO;
                end
                `SEL_PAIR_C: begin
                  form  <= `FORM_X;
                  base  <= POINTER_PAIR;
                  state <= S_DLO;
                end
                `SEL_INDIRECT: begin
                  form      <= `FORM_SX;
                  sx_second <= 1'b1;
                  state     <= S_D8;
                end
                default: begin
                  ILLEGAL <= 1'b1;
                end
              endcase
            end
          end
        end
        // The immediate byte is the source itself, so no memory access is needed.
        S_IMM: begin
          if (take) begin
            FLAGS <= cmp_flags(ACC, OP_BYTE, FLAGS);
            DONE  <= 1'b1;
            state <= S_IDLE;
          end
        end
        // The short displacement is sign-extended so it can reach below the index.
        S_D8: begin
          if (take) begin
            MEM_ADDR <= addr_sum(sx_second ? SECOND_INDEX : FIRST_INDEX,
                                 {{8{OP_BYTE[7]}}, OP_BYTE});
            state    <= S_MEM;
          end
        end
        S_DLO: begin
          if (take) begin
            disp_lo <= OP_BYTE;
            state   <= S_DHI;
          end
        end
        // The low byte arrived first; the high byte completes the 16-bit displacement.
        S_DHI: begin
          if (take) begin
            MEM_ADDR <= addr_sum(base, {OP_BYTE, disp_lo});
            state    <= S_MEM;
          end
        end
        // The operand fetch may take any number of cycles; decoding waits for it.
        S_MEM: begin
          if (MEM_VALID) begin
            FLAGS <= cmp_flags(ACC, MEM_DATA, FLAGS);
            DONE  <= 1'b1;
            state <= S_IDLE;
          end
        end
        // The register file answers in one cycle, so its data stands here.
        S_REG: begin
          FLAGS <= cmp_flags(ACC, REG_DATA, FLAGS);
          DONE  <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Read port; unmapped offsets answer zero.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA <= 8'h00;
    end else if (CE) begin
      if (BUS_RD) begin
        case (BUS_ADDR)
          `REG_FLAGS:  BUS_RDATA <= FLAGS;
          `REG_CTRL:   BUS_RDATA <= ctrl;
          `REG_STATUS: BUS_RDATA <= {3'h0, (state != S_IDLE), form};
          `REG_EA_LO:  BUS_RDATA <= MEM_ADDR[7:0];
          `REG_EA_HI:  BUS_RDATA <= MEM_ADDR[15:8];
          default:     BUS_RDATA <= 8'h00;
        endcase
      end else begin
        BUS_RDATA <= 8'h00;
      end
    end
  end

endmodule // compare_and_carry_complement

// *** core/cmp_ccf_defines.vh ***
// Constants for the compare and complement-carry datapath.
// Assumes inclusion by bare name from the single design file.
`ifndef COMPARE_FLAGS_DEFINES_VH
`define COMPARE_FLAGS_DEFINES_VH

// Opcode bytes, the upper five bits of the compare opcode and the source selectors.
`define OPC_INVERT_CARRY  8'h3f
`define OPC_PFX_FIRST     8'hdd
`define OPC_PFX_SECOND    8'hfd
`define OPC_IMMEDIATE     8'hfe
`define OPC_CMP_HI5       5'h17
`define SEL_INDIRECT      3'h6
`define SEL_DIRECT        3'h7
`define SEL_RELATIVE      3'h0
`define SEL_HIGH_BYTE     3'h4
`define SEL_LOW_BYTE      3'h5
`define SEL_PAIR_A        3'h1
`define SEL_PAIR_B        3'h2
`define SEL_PAIR_C        3'h3

// Flag bit positions.
`define FLG_S   7
`define FLG_Z   6
`define FLG_H   4
`define FLG_PV  2
`define FLG_N   1
`define FLG_C   0

// Software registers.
`define REG_FLAGS   4'h0
`define REG_CTRL    4'h1
`define REG_STATUS  4'h2
`define REG_EA_LO   4'h3
`define REG_EA_HI   4'h4
`define CTRL_EN     0
`define RST_FLAGS   8'h00
`define RST_CTRL    8'h01

// Source form codes.
`define FORM_REG         4'h0
`define FORM_RX          4'h1
`define FORM_IMM         4'h2
`define FORM_IR          4'h3
`define FORM_DA          4'h4
`define FORM_X           4'h5
`define FORM_SX          4'h6
`define FORM_RA          4'h7
`define FORM_SR          4'h8
`define FORM_BASE_INDEX  4'h9
`define FORM_INV_CARRY   4'hf

`endif

// *** verification/cmp_ccf_asserts.sv ***
// Port-level checker for the compare and invert-carry datapath.
// Assumes it is bound into the top module and sees nothing but its ports.
`timescale 1ns/10ps
module compare_flags_asserts (
  input wire        CLK,
  input wire        RST_N,
  input wire        CE,
  input wire        OP_VALID,
  input wire [7:0]  OP_BYTE,
  input wire        OP_READY,
  input wire [7:0]  ACC,
  input wire [15:0] FIRST_INDEX,
  input wire        MEM_REQ,
  input wire        MEM_VALID,
  input wire [7:0]  MEM_DATA,
  input wire [7:0]  FLAGS,
  input wire        DONE,
  input wire        ILLEGAL
);
  reg        fresh;
  reg  [7:0] lead;
  wire       take      = OP_VALID && OP_READY;
  wire       fresh_now = fresh || DONE || ILLEGAL;
  wire       inv_carry = take && fresh_now && OP_BYTE == 8'h3f;
  wire       mem       = MEM_REQ && MEM_VALID && CE;
  wire [8:0] diff      = {1'b0, ACC} - {1'b0, MEM_DATA};

  // A byte counts as an opcode only at a boundary, so operand bytes never look like opcodes.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fresh <= 1'b1;
      lead  <= 8'h00;
    end else if (take) begin
      fresh <= 1'b0;
      lead  <= fresh_now ? OP_BYTE : 8'h00;
    end else if (DONE || ILLEGAL) begin
      fresh <= 1'b1;
    end
  end

  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_N);

  inv_carry_a:
    assert property (inv_carry |=> DONE && FLAGS[0] == !$past(FLAGS[0])) else $error("carry not inverted");
  inv_side_a:
    assert property (inv_carry |=> FLAGS[4] == $past(FLAGS[0]) && !FLAGS[1] && FLAGS[7:5] == $past(FLAGS[7:5])
      && FLAGS[3:2] == $past(FLAGS[3:2])) else $error("invert carry side flags wrong");
  cmp_sign_a:
    assert property (mem |=> DONE && FLAGS[1] && FLAGS[7] == $past(diff[7])) else $error("compare sign wrong");
  cmp_zero_a:
    assert property (mem |=> FLAGS[6] == ($past(diff[7:0]) == 8'h00)) else $error("compare zero wrong");
  cmp_half_a:
    assert property (mem |=> FLAGS[4] == ($past(ACC[3:0]) < $past(MEM_DATA[3:0]))) else $error("half borrow wrong");
  cmp_ovf_a:
    assert property (mem |=> FLAGS[2] == ($past(ACC[7]) != $past(MEM_DATA[7]) && $past(diff[7]) == $past(MEM_DATA[7])))
      else $error("compare overflow wrong");
  cmp_carry_a:
    assert property (mem |=> FLAGS[0] == $past(diff[8])) else $error("compare borrow wrong");
  imm_carry_a:
    assert property (take && !fresh_now && lead == 8'hfe |=> DONE && FLAGS[0] == ($past(ACC) < $past(OP_BYTE)))
      else $error("immediate compare wrong");
  index_byte_a:
    assert property (take && !fresh_now && lead == 8'hdd && OP_BYTE[7:1] == 7'h5e |=> DONE && FLAGS[6] ==
      ($past(ACC) == ($past(OP_BYTE[0]) ? $past(FIRST_INDEX[7:0]) : $past(FIRST_INDEX[15:8]))))
      else $error("index byte compare wrong");
endmodule // compare_flags_asserts

bind compare_and_carry_complement compare_flags_asserts checker_i (.CLK, .RST_N, .CE, .OP_VALID, .OP_BYTE, .OP_READY,
  .ACC, .FIRST_INDEX, .MEM_REQ, .MEM_VALID, .MEM_DATA, .FLAGS, .DONE, .ILLEGAL);

// *** verification/compare_and_carry_complement_test.sv ***
// Self-checking bench for the compare and invert-carry datapath.
// Assumes the design is compiled first; the bench plays decoder, register file and memory.
`timescale 1ns/10ps
module compare_and_carry_complement_test;
  typedef struct {logic [31:0] s; int n; bit m; logic [15:0] a; logic [7:0] acc; logic [7:0] src;} row_t;
  reg          clk, rst_n, ce, op_valid, mem_valid, bus_wr, bus_rd;
  reg   [7:0]  op_byte, acc, mem_data, bus_wdata, flg;
  reg   [3:0]  bus_addr;
  wire         op_ready, mem_req, done, illegal;
  wire  [2:0]  reg_sel;
  wire  [7:0]  flags, bus_rdata, reg_data;
  wire  [15:0] mem_addr;
  wire  [2:0]  evt = {illegal, mem_req, done};
  int          failures, samples_checked, cycles;
  row_t        rows[16];

  // Register file answers at once, so its data is ready the cycle after selection.
  assign reg_data = {2'b00, reg_sel, 3'h5};

  compare_and_carry_complement dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .OP_VALID(op_valid), .OP_BYTE(op_byte),
    .OP_READY(op_ready), .ACC(acc), .REG_SEL(reg_sel), .REG_DATA(reg_data), .FIRST_INDEX(16'h2040),
    .SECOND_INDEX(16'h3080), .POINTER_PAIR(16'h2454), .STACK_POINTER(16'hff26), .PROG_COUNTER(16'h1630),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_VALID(mem_valid), .MEM_DATA(mem_data), .FLAGS(flags),
    .DONE(done), .ILLEGAL(illegal), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
    .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata));

  // A 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The whole run needs well under a thousand cycles; a hang stops here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize;
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Flags a compare must leave; bits it does not own keep their old value.
  function automatic logic [7:0] cmpf(input logic [7:0] old, input logic [7:0] a, input logic [7:0] s);
    logic [8:0] d;
    d = {1'b0, a} - {1'b0, s};
    cmpf = old;
    cmpf[7] = d[7];
    cmpf[6] = d[7:0] == 8'h00;
    cmpf[4] = a[3:0] < s[3:0];
    cmpf[2] = a[7] != s[7] && d[7] == s[7];
    cmpf[1] = 1'b1;
    cmpf[0] = d[8];
  endfunction

  task rd(input logic [3:0] a, input logic [7:0] exp);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    chk("bus_rdata", {8'h00, bus_rdata}, {8'h00, exp});
    @(posedge clk);
  endtask

  // A spare edge after each write keeps two strobe changes out of one time step.
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task wait_hi(input int w);
    int k;
    k = 0;
    @(negedge clk);
    while (evt[w] !== 1'b1 && k < 40) begin
      k++;
      @(negedge clk);
    end
    chk("event", {15'h0, evt[w]}, 16'h1);
  endtask

  task send(input logic [7:0] b);
    int k;
    op_byte  <= b;
    op_valid <= 1'b1;
    k = 0;
    @(negedge clk);
    while (op_ready !== 1'b1 && k < 40) begin
      k++;
      @(negedge clk);
    end
    chk("op_ready", {15'h0, op_ready}, 16'h1);
    @(posedge clk);
  endtask

  task finish_op(input logic [7:0] e);
    op_valid <= 1'b0;
    wait_hi(0);
    chk("flags", {8'h00, flags}, {8'h00, e});
    flg = e;
    @(posedge clk);
  endtask

  // A run of n invert-carry opcodes sent back to back.
  task invert_carry(input int n);
    logic [7:0] e;
    e = flg;
    for (int i = 0; i < n; i++) begin
      send(8'h3f);
      e = {e[7:5], e[0], e[3:2], 1'b0, ~e[0]};
    end
    finish_op(e);
  endtask

  task run(input row_t r);
    acc <= r.acc;
    for (int i = 0; i < r.n; i++) send(r.s[8*i +: 8]);
    if (r.m) begin
      op_valid <= 1'b0;
      wait_hi(1);
      chk("mem_addr", mem_addr, r.a);
      @(posedge clk);
      mem_valid <= 1'b1;
      mem_data  <= r.src;
      @(posedge clk);
      mem_valid <= 1'b0;
      mem_data  <= ~r.src;
    end
    finish_op(cmpf(flg, r.acc, r.src));
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    op_valid = 1'b0;
    op_byte = 8'h00;
    acc = 8'h00;
    mem_valid = 1'b0;
    mem_data = 8'h00;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    flg = 8'h00;
    rows = '{'{32'h000080fe,2,0,0,8'h7f,8'h80}, '{32'h0000bcdd,2,0,0,8'h20,8'h20}, '{32'h0000bddd,2,0,0,8'h41,8'h40},
      '{32'h000000ba,1,0,0,8'h15,8'h15}, '{32'h000000be,1,1,16'h2454,8'h48,8'h18},
      '{32'h1234bfdd,4,1,16'h1234,8'h80,8'h01}, '{32'h0010b9fd,4,1,16'h2050,8'h10,8'h20},
      '{32'h0010bafd,4,1,16'h3090,8'h55,8'h55}, '{32'hfffebbfd,4,1,16'h2452,8'h20,8'h01},
      '{32'h0080bedd,3,1,16'h1fc0,8'h7f,8'h80}, '{32'h007fbefd,3,1,16'h30ff,8'h00,8'h00},
      '{32'h0100b8fd,4,1,16'h1730,8'h01,8'hff}, '{32'h0004b8dd,4,1,16'hff2a,8'hc0,8'h40},
      '{32'h0000b9dd,2,1,16'h4494,8'h3c,8'h0f}, '{32'h0000badd,2,1,16'h54d4,8'h00,8'h01},
      '{32'h0000bbdd,2,1,16'h50c0,8'h90,8'h10}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h01);
    rd(4'hf, 8'h00);
    wr(4'h0, 8'h01);
    flg = 8'h01;
    invert_carry(1);
    invert_carry(2);
    wr(4'h0, 8'hea);
    flg = 8'hea;
    invert_carry(1);
    foreach (rows[i]) run(rows[i]);
    rd(4'h0, flg);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'hc0);
    rd(4'h4, 8'h50);
    send(8'hdd);
    send(8'h00);
    op_valid <= 1'b0;
    wait_hi(2);
    @(posedge clk);
    rd(4'h0, flg);
    wr(4'h1, 8'h00);
    @(negedge clk);
    chk("op_ready", {15'h0, op_ready}, 16'h0);
    @(posedge clk);
    wr(4'h1, 8'h01);
    ce <= 1'b0;
    @(negedge clk);
    chk("op_ready", {15'h0, op_ready}, 16'h0);
    @(posedge clk);
    ce <= 1'b1;
    invert_carry(1);
    summarize;
  end
endmodule // compare_and_carry_complement_test
